// file: core/ardx_pkg.sv
// Function
// RL1: read buffer returns exactly one sector from the sector buffer, no media access
// RL2: buffer and dma sector data move as 16-bit words, one per transfer
// RL3: read buffer reads the region that the last buffer write filled
// RL4: dma read accepted under both opcodes; retry bit ignored
// RL5: host programs its dma channel first; words move under dmarq/dmack
// RL6: dma read raises one interrupt, after transfer ends and status is valid
// RL7: dma read sector count zero means 256 sectors
// RL8: lba flag clear gives chs fields; set gives 28-bit block address
// RL9: uncorrectable media error stops dma read at the failing sector
// RL10: at end, count shows untransferred sectors; address shows last sector
// RL11: queued read takes its sector count from feature; zero means 256
// RL12: queued read tag sits in sector count bits 7..3 and stays with command
// RL13: queued read may release the bus or go straight to transfer
// RL14: after a release the host reselects with the service command
// RL15: once queued data moves, no further release until all sectors done
// RL16: on release, count shows tag, rel set, io and cd clear
// RL17: service bit clears on release, sets when data is ready
// RL18: queued completion shows tag, rel clear, io and cd set, service clear
// RL19: long read fetches one sector plus ecc in one attempt, unchecked
// RL20: long read keeps drq up through the ecc bytes after 512 data bytes
// RL21: long read returns 4 or 52 ecc bytes by config, 4 after reset
// RL22: host writes a sector count of one before a long read
package ardx_pkg;
    localparam logic [5:0] OFF_DATA     = 6'h00;
    localparam logic [5:0] OFF_FEAT_ERR = 6'h04;
    localparam logic [5:0] OFF_SECCNT   = 6'h08;
    localparam logic [5:0] OFF_SECNUM   = 6'h0C;
    localparam logic [5:0] OFF_CYL_LO   = 6'h10;
    localparam logic [5:0] OFF_CYL_HI   = 6'h14;
    localparam logic [5:0] OFF_DEVHEAD  = 6'h18;
    localparam logic [5:0] OFF_CMD_STAT = 6'h1C;
    localparam logic [5:0] OFF_CFG      = 6'h20;

    localparam logic [7:0] CMD_RD_BUF   = 8'hE4;
    localparam logic [7:0] CMD_RD_DMA   = 8'hC8;
    localparam logic [7:0] CMD_RD_DMAQ  = 8'hC7;
    localparam logic [7:0] CMD_RD_LONG  = 8'h22;
    localparam logic [7:0] CMD_SERVICE  = 8'hA2;

    localparam logic [8:0] SECTOR_WORDS = 9'h100;
    localparam logic [8:0] ECC_SHORT    = 9'h004;
    localparam logic [8:0] ECC_LONG     = 9'h034;
    localparam logic [8:0] ONE_SECTOR   = 9'h001;
    localparam logic [2:0] SC_REL       = 3'h4;
    localparam logic [2:0] SC_DONE      = 3'h3;

    localparam int ST_BSY    = 7;
    localparam int ST_RDY    = 6;
    localparam int ST_SRV    = 4;
    localparam int ST_DRQ    = 3;
    localparam int ST_ERR    = 0;
    localparam int ERR_UNC   = 6;
    localparam int ERR_ABT   = 2;
    localparam int DH_LBA    = 6;
    localparam int CFG_ECC52 = 0;

    localparam logic       REGION_WBUF  = 1'b0;
    localparam logic       REGION_MEDIA = 1'b1;
    localparam logic [7:0] TF_RESET     = 8'h00;
    localparam logic [7:0] CFG_RESET    = 8'h00;

    typedef struct packed {
        logic        lba_mode;
        logic [3:0]  head;
        logic [15:0] cyl;
        logic [7:0]  sector;
    } ardx_addr_t;

    typedef enum {S_IDLE, S_MEDIA, S_XFER, S_REL} ardx_state_t;
endpackage

// file: core/ardx_sector_ram.sv
`timescale 1ns/1ns
module ardx_sector_ram #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// file: core/ardx_read_exec.sv
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ns
module ardx_read_exec
    import ardx_pkg::*;
#(
    parameter int SPT   = 63,
    parameter int HEADS = 16
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             intrq,
    output logic             dmarq,
    input  wire logic        dmack,
    output logic      [15:0] dma_data,
    output logic             media_req,
    output ardx_addr_t       media_addr,
    output logic             media_long,
    input  wire logic        media_cached,
    input  wire logic        media_done,
    input  wire logic        media_uncorr,
    input  wire logic        fill_we,
    input  wire logic [9:0]  fill_addr,
    input  wire logic [15:0] fill_data
);
    ardx_state_t state;
    logic [7:0]  feature;
    logic [7:0]  seccnt;
    logic [7:0]  secnum;
    logic [7:0]  cyl_lo;
    logic [7:0]  cyl_hi;
    logic [7:0]  devhead;
    logic [7:0]  err;
    logic [7:0]  cfg;
    logic [7:0]  stat;
    logic        bsy;
    logic        drq;
    logic        srv;
    logic        errb;
    logic        is_dma;
    logic        is_q;
    logic        is_long;
    logic        region;
    logic        fetch_go;
    logic        rd_pend;
    logic        svc_ok;
    logic        svc_bad;
    logic [4:0]  tag;
    logic [8:0]  rem;
    logic [8:0]  widx;
    logic [8:0]  nwords;
    logic [15:0] rdata;
    logic [5:0]  off;
    logic        hit;
    logic        wr;
    logic        rd;
    logic        wr_cmd;
    logic        wr_svc;
    logic        rd_data;
    logic        cons;
    logic        last;
    logic        rel_ok;
    logic        rel_bad;
    logic        fin_ok;
    logic        fin_err;
    ardx_addr_t  cur;
    ardx_addr_t  nxt;

    // lba mode: head=27..24, cyl hi=23..16, cyl lo=15..8, sector=7..0
    function automatic ardx_addr_t addr_of(input logic [7:0] dh, input logic [7:0] ch,
                                           input logic [7:0] cl, input logic [7:0] sn);
        ardx_addr_t a;
        a.lba_mode = dh[DH_LBA];
        a.head     = dh[3:0];
        a.cyl      = {ch, cl};
        a.sector   = sn;
        return a;
    endfunction

    // chs walk wraps sector, then head, then cylinder
    function automatic ardx_addr_t next_addr(input ardx_addr_t a);
        ardx_addr_t n;
        n = a;
        if (a.lba_mode) begin
            {n.head, n.cyl, n.sector} = {a.head, a.cyl, a.sector} + 28'h0000001;
        end else if (a.sector < 8'(SPT)) begin
            n.sector = a.sector + 8'h01;
        end else begin
            n.sector = 8'h01;
            if (a.head == 4'(HEADS - 1)) begin
                n.head = 4'h0;
                n.cyl  = a.cyl + 16'h0001;
            end else begin
                n.head = a.head + 4'h1;
            end
        end
        return n;
    endfunction

    function automatic logic [8:0] cnt_of(input logic [7:0] v);
        return (v == 8'h00) ? SECTOR_WORDS : {1'b0, v};
    endfunction

    assign off     = {wb_adr_i[5:2], 2'b00};
    assign hit     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr      = hit & wb_we_i & wb_sel_i[0];
    assign rd      = hit & ~wb_we_i;
    assign wr_cmd  = wr & (off == OFF_CMD_STAT) & ~bsy;
    assign wr_svc  = wr_cmd & (wb_dat_i[7:0] == CMD_SERVICE);
    assign rd_data = rd & (off == OFF_DATA) & drq;
    assign cons    = (dmarq & dmack) | rd_data;
    assign last    = (widx == nwords - 9'h001);
    assign rel_ok  = svc_ok | (media_done & ~media_uncorr);
    assign rel_bad = svc_bad | (media_done & media_uncorr);
    assign fin_ok  = (state == S_XFER) & cons & last & (rem == ONE_SECTOR);
    assign fin_err = ((state == S_MEDIA) & media_done & media_uncorr)
                   | ((state == S_REL) & wr_svc & rel_bad);
    assign cur     = addr_of(devhead, cyl_hi, cyl_lo, secnum); // [RL8]
    assign nxt     = next_addr(cur);

    always_comb begin
        stat         = 8'h00;
        stat[ST_BSY] = bsy;
        stat[ST_RDY] = 1'b1;
        stat[ST_SRV] = is_q ? srv : 1'b1; // [RL17]
        stat[ST_DRQ] = drq;
        stat[ST_ERR] = errb;
    end

    ardx_sector_ram #(
        .AW (10),
        .DW (16)
    ) u_buf (
        .clk   (clk),
        .we    (fill_we),
        .waddr (fill_addr),
        .wdata (fill_data),
        .re    (fetch_go),
        .raddr ({region, widx}),
        .rdata (rdata)
    );

    // classic wishbone slave: ack one cycle after the take, unmapped reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= hit;
            if (rd) begin
                case (off)
                    OFF_DATA:     wb_dat_o <= {16'h0000, drq ? dma_data : 16'h0000}; // [RL2]
                    OFF_FEAT_ERR: wb_dat_o <= {24'h000000, err};
                    OFF_SECCNT:   wb_dat_o <= {24'h000000, seccnt};
                    OFF_SECNUM:   wb_dat_o <= {24'h000000, secnum};
                    OFF_CYL_LO:   wb_dat_o <= {24'h000000, cyl_lo};
                    OFF_CYL_HI:   wb_dat_o <= {24'h000000, cyl_hi};
                    OFF_DEVHEAD:  wb_dat_o <= {24'h000000, devhead};
                    OFF_CMD_STAT: wb_dat_o <= {24'h000000, stat};
                    OFF_CFG:      wb_dat_o <= {24'h000000, cfg};
                    default:      wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // command engine, task file and transfer pipeline share registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= S_IDLE;
            feature    <= TF_RESET;
            seccnt     <= TF_RESET;
            secnum     <= TF_RESET;
            cyl_lo     <= TF_RESET;
            cyl_hi     <= TF_RESET;
            devhead    <= TF_RESET;
            err        <= TF_RESET;
            cfg        <= CFG_RESET; // [RL21]
            bsy        <= 1'b0;
            drq        <= 1'b0;
            srv        <= 1'b0;
            errb       <= 1'b0;
            is_dma     <= 1'b0;
            is_q       <= 1'b0;
            is_long    <= 1'b0;
            region     <= REGION_WBUF;
            fetch_go   <= 1'b0;
            rd_pend    <= 1'b0;
            svc_ok     <= 1'b0;
            svc_bad    <= 1'b0;
            tag        <= 5'h00;
            rem        <= 9'h000;
            widx       <= 9'h000;
            nwords     <= SECTOR_WORDS;
            intrq      <= 1'b0;
            dmarq      <= 1'b0;
            dma_data   <= 16'h0000;
            media_req  <= 1'b0;
            media_addr <= '0;
            media_long <= 1'b0;
        end else begin
            fetch_go  <= 1'b0;
            rd_pend   <= fetch_go;
            media_req <= 1'b0;
            if (rd && off == OFF_CMD_STAT) begin
                intrq <= 1'b0;
            end
            // task file writes are ignored while busy
            if (wr && !bsy) begin
                case (off)
                    OFF_FEAT_ERR: feature <= wb_dat_i[7:0];
                    OFF_SECCNT:   seccnt  <= wb_dat_i[7:0];
                    OFF_SECNUM:   secnum  <= wb_dat_i[7:0];
                    OFF_CYL_LO:   cyl_lo  <= wb_dat_i[7:0];
                    OFF_CYL_HI:   cyl_hi  <= wb_dat_i[7:0];
                    OFF_DEVHEAD:  devhead <= wb_dat_i[7:0];
                    OFF_CFG:      cfg     <= wb_dat_i[7:0];
                    default:      ;
                endcase
            end
            if (rd_pend) begin
                // ecc words carry one byte in the low lane
                dma_data <= (widx >= SECTOR_WORDS) ? {8'h00, rdata[7:0]} : rdata; // [RL20]
                if (is_dma) begin
                    dmarq <= 1'b1; // [RL5]
                end else begin
                    drq <= 1'b1;
                    if (widx == 9'h000) begin
                        intrq <= 1'b1;
                    end
                end
            end
            if (cons) begin
                dmarq <= 1'b0;
                // pio drq stays up; the next word lands two cycles after the take, on the same edge as the earliest next read
                if (last) begin
                    drq <= 1'b0; // [RL20]
                end
            end
            case (state)
                S_IDLE: begin
                    if (wr_cmd) begin
                        intrq   <= 1'b0;
                        errb    <= 1'b0;
                        err     <= 8'h00;
                        widx    <= 9'h000;
                        is_dma  <= 1'b0;
                        is_q    <= 1'b0;
                        is_long <= 1'b0;
                        region  <= REGION_MEDIA;
                        nwords  <= SECTOR_WORDS;
                        bsy     <= 1'b1;
                        if (wb_dat_i[7:0] == CMD_RD_BUF) begin
                            region   <= REGION_WBUF; // [RL3]
                            rem      <= ONE_SECTOR; // [RL1]
                            fetch_go <= 1'b1;
                            state    <= S_XFER;
                        end else if (wb_dat_i[7:1] == CMD_RD_DMA[7:1]) begin
                            is_dma     <= 1'b1; // [RL4]
                            rem        <= cnt_of(seccnt); // [RL7]
                            media_req  <= 1'b1;
                            media_addr <= cur;
                            media_long <= 1'b0;
                            state      <= S_MEDIA;
                        end else if (wb_dat_i[7:0] == CMD_RD_DMAQ) begin
                            is_dma     <= 1'b1;
                            is_q       <= 1'b1;
                            tag        <= seccnt[7:3]; // [RL12]
                            rem        <= cnt_of(feature); // [RL11]
                            media_req  <= 1'b1;
                            media_addr <= cur;
                            media_long <= 1'b0;
                            svc_ok     <= 1'b0;
                            svc_bad    <= 1'b0;
                            if (media_cached) begin
                                srv   <= 1'b1;
                                state <= S_MEDIA; // [RL13]
                            end else begin
                                bsy    <= 1'b0;
                                srv    <= 1'b0; // [RL17]
                                seccnt <= {seccnt[7:3], SC_REL}; // [RL16]
                                state  <= S_REL; // [RL13]
                            end
                        end else if (wb_dat_i[7:1] == CMD_RD_LONG[7:1]) begin
                            is_long    <= 1'b1;
                            rem        <= ONE_SECTOR; // [RL22]
                            nwords     <= SECTOR_WORDS
                                        + (cfg[CFG_ECC52] ? ECC_LONG : ECC_SHORT); // [RL21]
                            media_req  <= 1'b1;
                            media_addr <= cur;
                            media_long <= 1'b1; // [RL19]
                            state      <= S_MEDIA;
                        end else begin
                            bsy          <= 1'b0;
                            err[ERR_ABT] <= 1'b1;
                            errb         <= 1'b1;
                            intrq        <= 1'b1;
                        end
                    end
                end
                S_MEDIA: begin
                    if (media_done && !media_uncorr) begin
                        widx     <= 9'h000;
                        fetch_go <= 1'b1;
                        state    <= S_XFER;
                    end
                end
                S_REL: begin
                    if (media_done) begin
                        srv     <= 1'b1; // [RL17]
                        svc_ok  <= ~media_uncorr;
                        svc_bad <= media_uncorr;
                    end
                    // the host must reselect before any word moves
                    if (wr_svc) begin
                        bsy <= 1'b1; // [RL14]
                        if (rel_ok) begin
                            widx     <= 9'h000;
                            fetch_go <= 1'b1;
                            state    <= S_XFER;
                        end else if (!rel_bad) begin
                            state <= S_MEDIA;
                        end
                    end
                end
                S_XFER: begin
                    // no path back to S_REL: a started queued transfer runs to its end
                    if (cons) begin
                        if (!last) begin
                            widx     <= widx + 9'h001;
                            fetch_go <= 1'b1;
                        end else if (rem != ONE_SECTOR) begin
                            rem        <= rem - 9'h001;
                            secnum     <= nxt.sector;
                            {cyl_hi, cyl_lo} <= nxt.cyl;
                            devhead[3:0] <= nxt.head;
                            media_req  <= 1'b1;
                            media_addr <= nxt;
                            state      <= S_MEDIA; // [RL15]
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
            if (fin_ok || fin_err) begin
                state <= S_IDLE;
                bsy   <= 1'b0;
                drq   <= 1'b0;
                dmarq <= 1'b0;
                intrq <= 1'b1; // [RL6]
                srv   <= 1'b0;
                if (is_q) begin
                    seccnt <= {tag, SC_DONE}; // [RL18]
                end else begin
                    seccnt <= fin_ok ? 8'h00 : rem[7:0]; // [RL10]
                end
                if (fin_err) begin
                    err[ERR_UNC] <= 1'b1; // [RL9]
                    errb         <= 1'b1;
                end
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_cmd(logic [7:0] op);
        wr_cmd && state == S_IDLE && wb_dat_i[7:0] == op;
    endsequence

    sequence s_rel_entry;
        state != S_REL ##1 state == S_REL;
    endsequence

    sequence s_q_finish;
        state == S_XFER && is_q ##1 state == S_IDLE;
    endsequence

    property p_irq_at_end;
        $rose(intrq) && is_dma |-> state == S_IDLE && !bsy && !dmarq;
    endproperty
    a_irq_at_end: assert property (p_irq_at_end) // [RL6]
        else $error("dma interrupt raised before the command ended");

    property p_retry_ignored;
        s_cmd(8'hC9) |=> state == S_MEDIA && is_dma && media_req;
    endproperty
    a_retry_ignored: assert property (p_retry_ignored) // [RL4]
        else $error("dma read with retry bit not accepted");

    property p_zero_count;
        s_cmd(8'hC8) and (seccnt == 8'h00) |=> rem == 9'h100;
    endproperty
    a_zero_count: assert property (p_zero_count) // [RL7]
        else $error("zero sector count not taken as 256");

    property p_q_count;
        s_cmd(8'hC7) |=> rem == cnt_of($past(feature)) && tag == $past(seccnt[7:3]);
    endproperty
    a_q_count: assert property (p_q_count) // [RL11]
        else $error("queued count or tag not latched");

    property p_uncorr_stop;
        state == S_MEDIA && media_done && media_uncorr
            |=> state == S_IDLE && err[ERR_UNC] && !dmarq ##1 !dmarq;
    endproperty
    a_uncorr_stop: assert property (p_uncorr_stop) // [RL9]
        else $error("transfer went on past an uncorrectable sector");

    property p_release;
        s_rel_entry |-> seccnt[2:0] == SC_REL && !srv && !bsy && seccnt[7:3] == tag;
    endproperty
    a_release: assert property (p_release) // [RL16]
        else $error("bus release status wrong");

    property p_q_done;
        s_q_finish |-> seccnt == {tag, SC_DONE} && !stat[ST_SRV] && intrq;
    endproperty
    a_q_done: assert property (p_q_done) // [RL18]
        else $error("queued completion status wrong");

    property p_no_second_release;
        state == S_XFER && is_q |=> state != S_REL;
    endproperty
    a_no_second_release: assert property (p_no_second_release) // [RL15]
        else $error("bus released during queued transfer");

    property p_buf_no_media;
        state == S_XFER && !is_dma && !is_long |-> !media_req && region == REGION_WBUF;
    endproperty
    a_buf_no_media: assert property (p_buf_no_media) // [RL1]
        else $error("read buffer touched media or wrong region");

    property p_long_words;
        state == S_XFER && is_long
            |-> nwords == SECTOR_WORDS + (cfg[CFG_ECC52] ? ECC_LONG : ECC_SHORT);
    endproperty
    a_long_words: assert property (p_long_words) // [RL21]
        else $error("long read word count wrong");
endmodule

// file: verif/ardx_media_model.sv
`timescale 1ns/1ns
module ardx_media_model
    import ardx_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  media_req,
    input  ardx_addr_t media_addr,
    input  wire logic  uncorr,
    output logic       fill_we,
    output logic [9:0] fill_addr,
    output logic [15:0] fill_data,
    output logic       media_done,
    output logic       media_uncorr,
    output logic       loaded
);
    logic slow;
    initial begin
        {fill_we, fill_addr, fill_data, media_done, media_uncorr, loaded, slow} = '0;
        // region 0 stands in for what the last buffer write left
        for (int i = 0; i < 256; i++) begin
            @(posedge clk);
            fill_we <= 1'b1;
            fill_addr <= i[9:0];
            fill_data <= {8'hB5, i[7:0]};
        end
        @(posedge clk);
        fill_we <= 1'b0;
        loaded <= 1'b1;
        forever begin
            @(posedge clk);
            if (media_req === 1'b1) begin
                // alternate prompt and slow fetches
                repeat (slow ? 40 : 2) @(posedge clk);
                slow = !slow;
                // data words then ecc bytes, always 52 stored
                for (int i = 0; i < 308; i++) begin
                    @(posedge clk);
                    fill_we <= 1'b1;
                    fill_addr <= {1'b1, i[8:0]};
                    fill_data <= {media_addr.sector, i[7:0]};
                end
                @(posedge clk);
                fill_we <= 1'b0;
                media_done <= 1'b1;
                media_uncorr <= uncorr;
                @(posedge clk);
                media_done <= 1'b0;
                media_uncorr <= 1'b0;
            end
        end
    end
endmodule

// file: verif/ardx_read_exec_tb.sv
`timescale 1ns/1ns
module ardx_read_exec_tb
    import ardx_pkg::*;
;
    logic clk, rst_n, cyc, stb, we, dmack, cached, uncorr, ack, intrq, dmarq, mreq, mlong;
    logic fwe, mdone, munc, loaded;
    logic [5:0]  adr;
    logic [31:0] dat, q, odat;
    logic [15:0] dma_data, fdata;
    logic [9:0]  faddr;
    ardx_addr_t  maddr;
    int          n_fail, samples_checked, cycles, n_req;

    ardx_read_exec i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(odat),
        .wb_ack_o(ack), .intrq(intrq), .dmarq(dmarq), .dmack(dmack), .dma_data(dma_data),
        .media_req(mreq), .media_addr(maddr), .media_long(mlong), .media_cached(cached),
        .media_done(mdone), .media_uncorr(munc), .fill_we(fwe), .fill_addr(faddr),
        .fill_data(fdata));
    ardx_media_model i_media (.clk(clk), .media_req(mreq), .media_addr(maddr),
        .uncorr(uncorr), .fill_we(fwe), .fill_addr(faddr), .fill_data(fdata),
        .media_done(mdone), .media_uncorr(munc), .loaded(loaded));

    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = odat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk({31'h0, ack}, 32'h1);
    endtask
    task automatic poll(input int b);
        int n = 0;
        do begin
            wb(1'b0, OFF_CMD_STAT, 8'h00);
            n++;
        end while (q[b] !== 1'b1 && n < 500);
    endtask
    task automatic pio(input int n, input logic [7:0] s);
        poll(ST_DRQ);
        for (int i = 0; i < n; i++) begin
            wb(1'b0, OFF_DATA, 8'h00);
            chk(q, i < 256 ? {16'h0, s, i[7:0]} : {24'h0, i[7:0]});
        end
        wb(1'b0, OFF_CMD_STAT, 8'h00);
        chk(q & 32'h89, 32'h0);
    endtask
    task automatic dma_words(input int n, input logic [7:0] s);
        for (int i = 0; i < n; i++) begin
            for (int t = 0; t < 2000 && dmarq !== 1'b1; t++) @(posedge clk);
            chk({16'h0, dma_data}, {16'h0, s, i[7:0]});
            chk({31'h0, intrq}, 32'h0);
            dmack <= 1'b1;
            @(posedge clk);
            dmack <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic wait_irq();
        for (int t = 0; t < 2000 && intrq !== 1'b1; t++) @(posedge clk);
        chk({31'h0, intrq}, 32'h1);
    endtask
    task automatic addr(input logic [7:0] c, input logic [7:0] s, input logic [7:0] h);
        wb(1'b1, OFF_SECCNT, c);
        wb(1'b1, OFF_SECNUM, s);
        wb(1'b1, OFF_CYL_LO, 8'h34);
        wb(1'b1, OFF_CYL_HI, 8'h56);
        wb(1'b1, OFF_DEVHEAD, h);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        n_req += (mreq === 1'b1);
        if (cycles == 60000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        {rst_n, cyc, stb, we, dmack, cached, uncorr, adr, dat} = '0;
        {n_fail, samples_checked, cycles, n_req} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait (loaded === 1'b1);
        // buffer readback
        wb(1'b1, OFF_CMD_STAT, CMD_RD_BUF);
        pio(256, 8'hB5);
        chk(n_req, 0);
        // dma read, retry opcode, lba, two sectors
        addr(8'h02, 8'h12, 8'hE7);
        wb(1'b1, OFF_CMD_STAT, CMD_RD_DMA | 8'h01);
        dma_words(256, 8'h12);
        dma_words(256, 8'h13);
        wait_irq();
        chk({3'h0, maddr}, {3'h0, 1'b1, 4'h7, 16'h5634, 8'h13});
        chk(n_req, 2);
        wb(1'b0, OFF_SECCNT, 8'h00);
        chk(q, 32'h0);
        wb(1'b0, OFF_SECNUM, 8'h00);
        chk(q, 32'h13);
        // uncorrectable error, first of 256 sectors
        uncorr <= 1'b1;
        addr(8'h00, 8'h01, 8'hA2);
        wb(1'b1, OFF_CMD_STAT, CMD_RD_DMA);
        wait_irq();
        uncorr <= 1'b0;
        chk({31'h0, dmarq}, 32'h0);
        chk(maddr.lba_mode, 1'b0);
        wb(1'b0, OFF_CMD_STAT, 8'h00);
        chk(q & 32'h89, 32'h01);
        wb(1'b0, OFF_FEAT_ERR, 8'h00);
        chk(q & 32'h40, 32'h40);
        wb(1'b0, OFF_SECCNT, 8'h00);
        chk(q, 32'h00);
        // queued read, tag 5, released then serviced, then a cached one with no release
        addr(8'h28, 8'h20, 8'hE0);
        wb(1'b1, OFF_FEAT_ERR, 8'h01);
        wb(1'b1, OFF_CMD_STAT, CMD_RD_DMAQ);
        wb(1'b0, OFF_SECCNT, 8'h00);
        chk(q, 32'h2C);
        wb(1'b0, OFF_CMD_STAT, 8'h00);
        chk(q & 32'h10, 32'h0);
        poll(ST_SRV);
        wb(1'b1, OFF_CMD_STAT, CMD_SERVICE);
        dma_words(256, 8'h20);
        wait_irq();
        wb(1'b0, OFF_SECCNT, 8'h00);
        chk(q, 32'h2B);
        wb(1'b0, OFF_CMD_STAT, 8'h00);
        chk(q & 32'h99, 32'h0);
        cached <= 1'b1;
        wb(1'b1, OFF_CMD_STAT, CMD_RD_DMAQ);
        dma_words(256, 8'h20);
        wait_irq();
        // long read, both opcodes and ecc counts
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, OFF_CFG, k[7:0]);
            addr(8'h01, 8'h05, 8'hA0);
            wb(1'b1, OFF_CMD_STAT, CMD_RD_LONG | k[7:0]);
            pio(k ? 308 : 260, 8'h05);
            chk(mlong, 1'b1);
        end
        report_and_stop();
    end
endmodule
